/* File: rtl/supply_seq_pkg.sv */
package supply_seq_pkg;

   // Register byte addresses on the bus.
   localparam logic [31:0] ADDR_CTRL    = 32'h0000_0000;
   localparam logic [31:0] ADDR_STATUS  = 32'h0000_0004;
   localparam logic [5:0]  CTRL_RESET   = 6'h00;

   // Status register field positions.
   localparam int ST_BUCK  = 0;
   localparam int ST_LOGIC = 1;
   localparam int ST_LIN   = 2;
   localparam int ST_SEQ   = 6;
   localparam int ST_FAULT = 7;
   localparam int ST_THERM = 8;
   localparam int ST_RST   = 9;
   localparam int ST_DONE  = 10;

   // Clock rates and the switching clock dividers.
   localparam int HCLK_HZ       = 40_000_000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int SW_HZ_SLOW    = 250_000;
   localparam int SW_HZ_FAST    = 500_000;
   localparam logic [7:0] DIV_SLOW = 8'(HCLK_HZ / SW_HZ_SLOW);
   localparam logic [7:0] DIV_FAST = 8'(HCLK_HZ / SW_HZ_FAST);

   // Soft-start shape: steps and total switching cycles per ramp.
   localparam int RAMP_STEPS        = 32;
   localparam int RAMP_CYCLES_SLOW  = 1024;
   localparam int RAMP_CYCLES_FAST  = 2048;
   localparam int TPS_SLOW          = RAMP_CYCLES_SLOW / RAMP_STEPS;
   localparam int TPS_FAST          = RAMP_CYCLES_FAST / RAMP_STEPS;

   // Overcurrent glitch filter, a longest time so it rounds down.
   localparam int OC_FILTER_NS     = 50_000;
   localparam int OC_FILTER_CYCLES = OC_FILTER_NS / CLK_PERIOD_NS;

   // Default supervisor timeout and undervoltage timer, in switching cycles.
   localparam int RESET_TIMEOUT_DEF = 256;
   localparam int UV_TIMER_DEF      = 128;

   // Rail layout: 0 step-down, 1 logic, 2..5 linear, 5 is the negative one.
   localparam int NUM_RAILS = 6;
   localparam int NUM_DELAY = 4;
   localparam int NEG_RAIL  = 5;

endpackage

/* File: rtl/ramp_if.sv */
`timescale 1ns/1ps
interface ramp_if;
   logic       en;
   logic       tick;
   logic       fast;
   logic       neg;
   logic [5:0] level;
   logic       done;
   modport ctl  (output en, output tick, output fast, output neg, input level, input done);
   modport ramp (input en, input tick, input fast, input neg, output level, output done);
endinterface

/* File: rtl/soft_start_ramp.sv */
`timescale 1ns/1ps
module soft_start_ramp (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   ramp_if.ramp     rp
);
   import supply_seq_pkg::*;

   logic [5:0] sub_q;
   logic [5:0] step_q;
   logic [5:0] level_q;
   logic       step_end;

   // A step ends after 32 or 64 switching ticks, set by the rate.
   assign step_end = rp.fast ? (sub_q == 6'(TPS_FAST - 1)) : (sub_q == 6'(TPS_SLOW - 1));

   // The ramp restarts whenever its rail is off and climbs once enabled, or falls on the negative rail.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sub_q   <= 6'h00;
         step_q  <= 6'h00;
         level_q <= 6'h00;
      end else if (ce) begin
         if (!rp.en) begin
            sub_q   <= 6'h00;
            step_q  <= 6'h00;
            level_q <= rp.neg ? 6'(RAMP_STEPS) : 6'h00;
         end else if (rp.tick && step_q != 6'(RAMP_STEPS)) begin
            if (step_end) begin
               sub_q   <= 6'h00;
               step_q  <= step_q + 6'h01;
               level_q <= rp.neg ? level_q - 6'h01 : level_q + 6'h01;
            end else begin
               sub_q <= sub_q + 6'h01;
            end
         end
      end
   end

   assign rp.level = level_q;
   assign rp.done  = (step_q == 6'(RAMP_STEPS));

   // A disabled rail always sits at the start of its ramp.
   ramp_restart_a : assert property (@(posedge hclk) disable iff (!hresetn)
      ce && !rp.en |=> step_q == 6'h00 && !rp.done)
      else $error("ramp did not restart while disabled");

endmodule // soft_start_ramp

/* File: rtl/supply_sequencer_faults.sv */
`timescale 1ns/1ps
module supply_sequencer_faults #(
   parameter int RESET_TIMEOUT_TICKS = supply_seq_pkg::RESET_TIMEOUT_DEF,
   parameter int UV_TIMER_TICKS      = supply_seq_pkg::UV_TIMER_DEF
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        supply_above_lockout,
   input  wire logic        enable_cmp,
   input  wire logic        sequence_control_pin,
   input  wire logic        switching_rate_select,
   input  wire logic [supply_seq_pkg::NUM_DELAY-1:0] rail_delay_pin_cmp,
   input  wire logic        reset_monitor_input,
   input  wire logic [supply_seq_pkg::NUM_RAILS-1:0] rail_output_good,
   input  wire logic        current_sense_over,
   input  wire logic        over_temp,
   output logic             step_down_en,
   output logic             logic_rail_controller_en,
   output logic [supply_seq_pkg::NUM_DELAY-1:0] linear_rail_controller_en,
   output logic             sequence_block_en,
   output logic [supply_seq_pkg::NUM_DELAY-1:0] rail_delay_pin_source_on,
   output logic [supply_seq_pkg::NUM_DELAY-1:0] rail_delay_pin_pulldown_on,
   output logic [6*supply_seq_pkg::NUM_RAILS-1:0] ramp_level,
   output logic             gate_drive_permit,
   output logic             internal_5v_rail_en,
   output logic             reset_out_o,
   output logic             reset_out_oe
);
   import supply_seq_pkg::*;

   localparam int SYNC_W    = NUM_RAILS + NUM_DELAY + 7;
   localparam int OC_LAST   = OC_FILTER_CYCLES - 1;
   localparam int RST_LAST  = RESET_TIMEOUT_TICKS - 1;
   localparam int UV_LAST   = UV_TIMER_TICKS - 1;

   logic [SYNC_W-1:0]    sync_m_q;
   logic [SYNC_W-1:0]    sync_s_q;
   logic                 lock_s;
   logic                 en_s;
   logic                 seq_s;
   logic                 rate_s;
   logic                 rstmon_s;
   logic                 oc_s;
   logic                 otemp_s;
   logic [NUM_DELAY-1:0] delay_s;
   logic [NUM_RAILS-1:0] good_s;
   logic                 lock_d_q;
   logic                 en_d_q;
   logic                 seq_d_q;
   logic                 rise_lock;
   logic                 rise_en;
   logic                 rise_seq;
   logic [7:0]           div_q;
   logic                 tick;
   logic                 buck_d;
   logic                 buck_q;
   logic                 logic_q;
   logic [NUM_DELAY-1:0] lin_q;
   logic                 seqblk_q;
   logic [NUM_DELAY-1:0] src_q;
   logic                 gate_q;
   logic [NUM_RAILS-1:0] rail_on;
   logic [NUM_RAILS-1:0] ramp_done;
   logic                 fault_q;
   logic                 thermal_q;
   logic                 fault_set;
   logic                 fault_clr;
   logic                 uv_cond;
   logic                 uv_hit;
   logic [15:0]          uv_cnt_q;
   logic [11:0]          oc_cnt_q;
   logic                 oc_hit;
   logic                 rst_hold;
   logic [15:0]          rst_cnt_q;
   logic                 rst_rel_q;
   logic [5:0]           ctrl_q;
   logic                 ph_q;
   logic                 wr_q;
   logic                 hit_ctrl_q;
   logic                 hit_stat_q;
   logic [31:0]          rdata_q;
   logic [31:0]          status;

   // Two-stage synchroniser for every comparator and pin input.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_m_q <= '0;
         sync_s_q <= '0;
      end else if (ce) begin
         sync_m_q <= {rail_output_good, rail_delay_pin_cmp, over_temp, current_sense_over,
                      reset_monitor_input, switching_rate_select, sequence_control_pin,
                      enable_cmp, supply_above_lockout};
         sync_s_q <= sync_m_q;
      end
   end

   // Named views of the synchronised inputs.
   assign lock_s   = sync_s_q[0];
   assign en_s     = sync_s_q[1];
   assign seq_s    = sync_s_q[2];
   assign rate_s   = sync_s_q[3];
   assign rstmon_s = sync_s_q[4];
   assign oc_s     = sync_s_q[5];
   assign otemp_s  = sync_s_q[6];
   assign delay_s  = sync_s_q[7 +: NUM_DELAY];
   assign good_s   = sync_s_q[7+NUM_DELAY +: NUM_RAILS];

   // Delayed copies for rising-edge detection.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock_d_q <= 1'b0;
         en_d_q   <= 1'b0;
         seq_d_q  <= 1'b0;
      end else if (ce) begin
         lock_d_q <= lock_s;
         en_d_q   <= en_s;
         seq_d_q  <= seq_s;
      end
   end

   assign rise_lock = lock_s && !lock_d_q;
   assign rise_en   = en_s && !en_d_q;
   assign rise_seq  = seq_s && !seq_d_q;

   // Switching clock tick generator; the rate pin picks the divider.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q <= 8'h00;
      end else if (ce) begin
         if (tick) begin
            div_q <= rate_s ? DIV_FAST - 8'h01 : DIV_SLOW - 8'h01;
         end else begin
            div_q <= div_q - 8'h01;
         end
      end
   end

   assign tick = (div_q == 8'h00);

   // Step-down enable needs all four startup conditions.
   assign buck_d = lock_s && en_s && !fault_q && !thermal_q;

   // Regulator enables, sequence block and delay pin drive.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         buck_q   <= 1'b0;
         logic_q  <= 1'b0;
         lin_q    <= '0;
         seqblk_q <= 1'b0;
         src_q    <= '0;
         gate_q   <= 1'b0;
      end else if (ce) begin
         buck_q   <= buck_d;
         logic_q  <= buck_d && ramp_done[0];
         seqblk_q <= buck_d;
         lin_q    <= {NUM_DELAY{buck_d}} & delay_s;
         src_q    <= {NUM_DELAY{seq_s && buck_d}};
         gate_q   <= buck_d && lock_s;
      end
   end

   assign rail_on = {lin_q, logic_q, buck_q};

   // One soft-start ramp per rail, each restarted by its own enable.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_RAILS; gi++) begin : g_ramp
         ramp_if rif ();
         assign rif.en   = rail_on[gi];
         assign rif.tick = tick;
         assign rif.fast = rate_s;
         assign rif.neg  = (gi == NEG_RAIL);
         assign ramp_done[gi] = rif.done;
         assign ramp_level[6*gi +: 6] = rif.level;
         soft_start_ramp u_ramp (
            .hclk    (hclk),
            .hresetn (hresetn),
            .ce      (ce),
            .rp      (rif.ramp)
         );
      end
   endgenerate

   // Undervoltage timer runs only while a ramped-up rail sits below 90%.
   assign uv_cond = |(rail_on & ramp_done & ~good_s & ~ctrl_q);
   assign uv_hit  = uv_cond && tick && (uv_cnt_q == 16'(UV_LAST));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         uv_cnt_q <= 16'h0000;
      end else if (ce) begin
         if (!uv_cond) begin
            uv_cnt_q <= 16'h0000;
         end else if (tick && uv_cnt_q != 16'(UV_LAST)) begin
            uv_cnt_q <= uv_cnt_q + 16'h0001;
         end
      end
   end

   // Overcurrent must be held continuously through the filter window.
   assign oc_hit = oc_s && (oc_cnt_q == 12'(OC_LAST));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         oc_cnt_q <= 12'h000;
      end else if (ce) begin
         if (!oc_s) begin
            oc_cnt_q <= 12'h000;
         end else if (oc_cnt_q != 12'(OC_LAST)) begin
            oc_cnt_q <= oc_cnt_q + 12'h001;
         end
      end
   end

   // Fault latch: a new fault wins over any clear in the same cycle.
   assign fault_set = uv_hit || oc_hit;
   assign fault_clr = rise_en || rise_seq || rise_lock;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fault_q <= 1'b0;
      end else if (ce) begin
         if (fault_set) begin
            fault_q <= 1'b1;
         end else if (fault_clr) begin
            fault_q <= 1'b0;
         end
      end
   end

   // Thermal latch ignores the enable edge; only leaving lockout clears it.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         thermal_q <= 1'b0;
      end else if (ce) begin
         if (otemp_s) begin
            thermal_q <= 1'b1;
         end else if (rise_lock) begin
            thermal_q <= 1'b0;
         end
      end
   end

   // Supervisor: any hold condition restarts the timeout from zero.
   assign rst_hold = !rstmon_s || !lock_s || !en_s || thermal_q || fault_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rst_cnt_q <= 16'h0000;
         rst_rel_q <= 1'b0;
      end else if (ce) begin
         if (rst_hold) begin
            rst_cnt_q <= 16'h0000;
            rst_rel_q <= 1'b0;
         end else if (tick && !rst_rel_q) begin
            if (rst_cnt_q == 16'(RST_LAST)) begin
               rst_rel_q <= 1'b1;
            end else begin
               rst_cnt_q <= rst_cnt_q + 16'h0001;
            end
         end
      end
   end

   // Output pins; the reset pin is open drain and read by no other logic.
   assign reset_out_o                = 1'b0;
   assign reset_out_oe               = !rst_rel_q;
   assign step_down_en               = buck_q;
   assign logic_rail_controller_en   = logic_q;
   assign linear_rail_controller_en  = lin_q;
   assign sequence_block_en          = seqblk_q;
   assign rail_delay_pin_source_on   = src_q;
   assign rail_delay_pin_pulldown_on = ~src_q;
   assign gate_drive_permit          = gate_q;
   assign internal_5v_rail_en        = !thermal_q;

   // Status word gathered from the block's own state.
   always_comb begin
      status                          = 32'h0000_0000;
      status[ST_BUCK]                 = buck_q;
      status[ST_LOGIC]                = logic_q;
      status[ST_LIN +: NUM_DELAY]     = lin_q;
      status[ST_SEQ]                  = seqblk_q;
      status[ST_FAULT]                = fault_q;
      status[ST_THERM]                = thermal_q;
      status[ST_RST]                  = rst_rel_q;
      status[ST_DONE +: NUM_RAILS]    = ramp_done;
   end

   // Bus slave: the address phase is captured, then one wait state follows.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_q       <= 1'b0;
         wr_q       <= 1'b0;
         hit_ctrl_q <= 1'b0;
         hit_stat_q <= 1'b0;
      end else if (ce) begin
         if (ph_q) begin
            ph_q <= 1'b0;
         end else if (hsel && hready && htrans[1]) begin
            ph_q       <= 1'b1;
            wr_q       <= hwrite;
            hit_ctrl_q <= (haddr == ADDR_CTRL);
            hit_stat_q <= (haddr == ADDR_STATUS);
         end
      end
   end

   // Control register write and read data capture in the wait state.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q  <= CTRL_RESET;
         rdata_q <= 32'h0000_0000;
      end else if (ce && ph_q) begin
         if (wr_q && hit_ctrl_q) begin
            ctrl_q <= hwdata[5:0];
         end
         if (!wr_q) begin
            rdata_q <= hit_ctrl_q ? {26'h0000000, ctrl_q} : (hit_stat_q ? status : 32'h0000_0000);
         end
      end
   end

   assign hreadyout = !ph_q;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_q;

   // Any missing startup condition keeps the step-down off.
   buck_gate_a : assert property (@(posedge hclk) disable iff (!hresetn)
      ce && (fault_q || thermal_q || !lock_s || !en_s) |=> !step_down_en)
      else $error("step-down enabled without all conditions");

   // Logic rail starts only after the step-down ramp is done.
   logic_order_a : assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(logic_rail_controller_en) |-> $past(ramp_done[0]) && step_down_en)
      else $error("logic rail started before step-down ramp finished");

   // Sequence block follows the step-down enable in the same cycle.
   seq_same_a : assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(step_down_en) |-> $rose(sequence_block_en))
      else $error("sequence block not enabled with step-down");

   // Delay pins source current when sequencing is active.
   delay_source_a : assert property (@(posedge hclk) disable iff (!hresetn)
      ce && seq_s && buck_d |=> rail_delay_pin_source_on == 4'hF && rail_delay_pin_pulldown_on == 4'h0)
      else $error("delay pins not sourcing while sequencing");

   // Delay pins are grounded when the sequence pin is low.
   delay_pull_a : assert property (@(posedge hclk) disable iff (!hresetn)
      ce && !seq_s |=> rail_delay_pin_pulldown_on == 4'hF)
      else $error("delay pins not pulled down");

   // A linear controller never runs before its delay comparator trips.
   linear_start_a : assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(linear_rail_controller_en[0]) |-> $past(delay_s[0]) && step_down_en)
      else $error("linear controller started without its delay threshold");

   // Lockout holds the gate drive off.
   gate_lock_a : assert property (@(posedge hclk) disable iff (!hresetn)
      ce && !lock_s |=> !gate_drive_permit)
      else $error("gate drive permitted during lockout");

   // Enable edge clears the fault latch unless a new fault arrives.
   fault_clear_a : assert property (@(posedge hclk) disable iff (!hresetn)
      ce && rise_en && !fault_set |=> !fault_q)
      else $error("enable edge did not clear fault latch");

   // Over-temperature latches and drops the internal supply next cycle.
   thermal_set_a : assert property (@(posedge hclk) disable iff (!hresetn)
      ce && otemp_s |=> thermal_q && !internal_5v_rail_en)
      else $error("thermal latch did not set");

   // Leaving lockout clears the thermal latch when no new heat event is seen.
   thermal_clear_a : assert property (@(posedge hclk) disable iff (!hresetn)
      ce && rise_lock && !otemp_s |=> !thermal_q)
      else $error("lockout release did not clear thermal latch");

   // An overcurrent-caused fault needs the full filter window first.
   oc_filter_a : assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(fault_q) && !$past(uv_hit) |-> $past(oc_cnt_q) == 12'(OC_LAST))
      else $error("fault latched on a short overcurrent");

   // An undervoltage fault needs the full timer first.
   uv_timer_a : assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(fault_q) && !$past(oc_hit) |-> $past(uv_cnt_q) == 16'(UV_LAST))
      else $error("fault latched before undervoltage timer ran out");

   // Monitor low pulls reset low on the next cycle.
   reset_low_a : assert property (@(posedge hclk) disable iff (!hresetn)
      ce && !rstmon_s |=> reset_out_oe)
      else $error("reset released while monitor low");

   // Reset releases only at the end of a full timeout.
   reset_rel_a : assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(reset_out_oe) |-> $past(rst_cnt_q) == 16'(RST_LAST))
      else $error("reset released before timeout");

endmodule // supply_sequencer_faults

/* File: verification/far_side_model.sv */
`timescale 1ns/1ps
// Analog far side: delay pins charge while sourced, rail outputs read good while enabled.
module far_side_model #(
   parameter int CHARGE = 40
) (
   hclk,
   source_on,
   rails_en,
   delay_cmp,
   rail_good
);
   input  wire logic       hclk;
   input  wire logic [3:0] source_on;
   input  wire logic [5:0] rails_en;
   output logic      [3:0] delay_cmp;
   output logic      [5:0] rail_good;
   int lvl [4] = '{0, 0, 0, 0};
   // Each pin ramps at its own rate so the linear controllers start in turn; the pull-down empties it.
   always @(posedge hclk) begin
      for (int i = 0; i < 4; i++) begin
         lvl[i] <= source_on[i] ? lvl[i] + i + 1 : 0;
      end
   end
   // The comparator trips once the pin reaches its threshold level.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         delay_cmp[i] = (lvl[i] >= CHARGE);
      end
   end
   assign rail_good = rails_en;
endmodule // far_side_model

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import supply_seq_pkg::*;
   logic hclk = 0, hresetn = 0, ce = 1, hsel = 1, hwrite = 0, hreadyout, hresp, supply_above_lockout = 0;
   logic enable_cmp = 0, sequence_control_pin = 0, switching_rate_select = 0, reset_monitor_input = 0;
   logic current_sense_over = 0, over_temp = 0, step_down_en, logic_rail_controller_en, sequence_block_en;
   logic gate_drive_permit, internal_5v_rail_en, reset_out_o, reset_out_oe;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   logic [3:0]  rail_delay_pin_cmp, linear_rail_controller_en, rail_delay_pin_source_on, rail_delay_pin_pulldown_on;
   logic [5:0]  rail_output_good, r6;
   logic [35:0] ramp_level;
   wire         hready = hreadyout;
   int fail_count = 0, cmp_count = 0, n;
   supply_sequencer_faults #(.RESET_TIMEOUT_TICKS(4), .UV_TIMER_TICKS(4)) DUT (
      .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .supply_above_lockout(supply_above_lockout),
      .enable_cmp(enable_cmp), .sequence_control_pin(sequence_control_pin),
      .switching_rate_select(switching_rate_select), .rail_delay_pin_cmp(rail_delay_pin_cmp),
      .reset_monitor_input(reset_monitor_input), .rail_output_good(rail_output_good),
      .current_sense_over(current_sense_over), .over_temp(over_temp), .step_down_en(step_down_en),
      .logic_rail_controller_en(logic_rail_controller_en),
      .linear_rail_controller_en(linear_rail_controller_en), .sequence_block_en(sequence_block_en),
      .rail_delay_pin_source_on(rail_delay_pin_source_on),
      .rail_delay_pin_pulldown_on(rail_delay_pin_pulldown_on), .ramp_level(ramp_level),
      .gate_drive_permit(gate_drive_permit), .internal_5v_rail_en(internal_5v_rail_en),
      .reset_out_o(reset_out_o), .reset_out_oe(reset_out_oe));
   far_side_model FS (.hclk(hclk), .source_on(rail_delay_pin_source_on), .delay_cmp(rail_delay_pin_cmp),
      .rails_en({linear_rail_controller_en, logic_rail_controller_en, step_down_en}), .rail_good(rail_output_good));
   // Free-running 40 MHz clock.
   initial begin
      forever #12.5 hclk = ~hclk;
   end
   task automatic complete_run;
      if (fail_count == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge hclk);
   endtask
   // Design output picked by number, so a wait can watch a net without a reference argument.
   function automatic logic pick(input int k);
      case (k)
         0: return hready;
         1: return step_down_en;
         default: return reset_out_oe;
      endcase
   endfunction
   // Bounded wait for a design output to reach a level; a hang ends the run.
   task automatic wait_for(input int k, input logic v, input int lim);
      n = 0;
      while (pick(k) !== v && n < lim) begin
         @(posedge hclk);
         n++;
      end
      if (n >= lim) begin
         fail_count++;
         $display("ERROR %0t wait for design output timed out", $time);
         complete_run();
      end
   endtask
   // One single AHB-Lite transfer: address phase, then data phase until hready is seen high.
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      @(posedge hclk);
      wait_for(0, 1'b1, 50);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      wait_for(0, 1'b1, 50);
      q = hrdata;
   endtask
   initial begin
      void'($urandom(44));
      r6 = 6'($urandom);
      cyc(12);
      hresetn <= 1;
      cyc(3);
      chk(ramp_level[35:30], 32'h20);
      bus(1, ADDR_CTRL, {26'h0, r6});
      bus(0, ADDR_CTRL, 0);
      chk(q, {26'h0, r6});
      bus(0, 32'h40, 0);
      chk(q, 0);
      supply_above_lockout <= 1;
      enable_cmp <= 1;
      sequence_control_pin <= 1;
      reset_monitor_input <= 1;
      wait_for(1, 1'b1, 20);
      chk(sequence_block_en, 1);
      cyc(5);
      chk(rail_delay_pin_source_on, 32'hF);
      cyc(60);
      chk(linear_rail_controller_en, 32'hF);
      for (int r = 0; r < 2; r++) begin
         switching_rate_select <= r[0];
         enable_cmp <= 0;
         cyc(8);
         chk({step_down_en, logic_rail_controller_en, linear_rail_controller_en, internal_5v_rail_en}, 1);
         chk(reset_out_oe, 1);
         enable_cmp <= 1;
         wait_for(1, 1'b1, 20);
         chk(ramp_level[5:0], 0);
         while (ramp_level[5:0] !== 6'h1 && n < 9000) begin @(posedge hclk); n++; end
         n = 0;
         while (ramp_level[5:0] !== 6'h2 && n < 9000) begin @(posedge hclk); n++; end
         chk(n, r ? DIV_FAST * TPS_FAST : DIV_SLOW * TPS_SLOW);
      end
      wait_for(2, 1'b0, 2000);
      reset_monitor_input <= 0;
      cyc(5);
      chk(reset_out_oe, 1);
      reset_monitor_input <= 1;
      cyc(100);
      chk(reset_out_oe, 1);
      current_sense_over <= 1;
      cyc(1000 + $urandom % 900);
      current_sense_over <= 0;
      cyc(5);
      chk(step_down_en, 1);
      current_sense_over <= 1;
      cyc(2100);
      current_sense_over <= 0;
      bus(0, ADDR_STATUS, 0);
      chk({q[ST_FAULT], step_down_en, internal_5v_rail_en}, 32'h5);
      enable_cmp <= 0;
      cyc(5);
      enable_cmp <= 1;
      cyc(5);
      chk(step_down_en, 1);
      current_sense_over <= 1;
      cyc(2100);
      current_sense_over <= 0;
      sequence_control_pin <= 0;
      cyc(5);
      chk(step_down_en, 0);
      sequence_control_pin <= 1;
      cyc(5);
      chk(step_down_en, 1);
      over_temp <= 1;
      cyc(5);
      over_temp <= 0;
      enable_cmp <= 0;
      cyc(5);
      enable_cmp <= 1;
      cyc(5);
      chk({internal_5v_rail_en, step_down_en}, 0);
      supply_above_lockout <= 0;
      sequence_control_pin <= 0;
      cyc(5);
      chk({gate_drive_permit, rail_delay_pin_pulldown_on}, 32'hF);
      supply_above_lockout <= 1;
      cyc(5);
      chk({internal_5v_rail_en, step_down_en}, 3);
      complete_run();
   end
endmodule // tb_top
